// File: rtl/cts_scheduler.v
/*
  Coherent transaction scheduler with its bus slave and bus master faces.
  Assumes the bus pad logic, the dram sequencer and the io controller all
  run on mclk_in and present one transaction per cycle at most.
*/
// What this block does
// - Each bus write sends address to scheduling and data to the write data buffer.
// - Cache-to-cache writes carrying the io controller identifier also go to it.
// - Every write takes a map index, held until memory, and joins the write queue.
// - Write queue head is issued to memory; completion frees its map entry.
// - Every non-coherent read holds a read map entry until its return finishes.
// - Empty read queue means bypass in one state, otherwise queue, two states.
// - Read queue head waits while conflicting writes drain, then issues.
// - Early index from memory puts the read into the return queue.
// - Return queue head sends buffered data out on the bus, freeing the entry.
// - Coherent bus reads are also sent to the io controller for snooping.
// - Coherent reads hold their entry through response phase and also join the response queue.
// - Response head records response, checks conflict, drains, waits, then reissues.
// - Without conflict the response head pops and nothing is issued.
// - Data already buffered with OK or SHARED response schedules the return at once.
// - Early index of a coherent read schedules return only after its response phase.
// - Reads reissued from the response queue carry the marked flag.
// - Io controller writes go out on the bus and come back like processor writes.
// - Io controller coherent reads go out, reflect back, and returns reach it.
`timescale 1ns/10ps
`include "cts_map.vh"

module cts_scheduler (
  input wire mclk_in,
  input wire sys_rst_in,
  input wire bus_valid_in,
  input wire [`CTS_KIND_W-1:0] bus_kind_in,
  input wire [`CTS_ID_W-1:0] bus_master_id_in,
  input wire [`CTS_ADDR_W-1:0] bus_addr_in,
  input wire [`CTS_DATA_W-1:0] bus_data_in,
  input wire bus_grant_in,
  input wire coh_resp_valid_in,
  input wire [`CTS_RESP_W-1:0] coh_resp_in,
  input wire mem_cmd_ready_in,
  input wire mem_wr_done_in,
  input wire [`CTS_IDX_W-1:0] mem_wr_done_idx_in,
  input wire mem_rd_early_in,
  input wire [`CTS_IDX_W-1:0] mem_rd_early_idx_in,
  input wire mem_rd_data_valid_in,
  input wire [`CTS_IDX_W-1:0] mem_rd_data_idx_in,
  input wire [`CTS_DATA_W-1:0] mem_rd_data_in,
  input wire ioc_req_valid_in,
  input wire ioc_req_write_in,
  input wire [`CTS_ADDR_W-1:0] ioc_req_addr_in,
  input wire [`CTS_DATA_W-1:0] ioc_req_data_in,
  output reg bus_busy_out,
  output reg bus_req_out,
  output reg out_valid_out,
  output reg out_return_out,
  output reg out_write_out,
  output reg [`CTS_ADDR_W-1:0] out_addr_out,
  output reg [`CTS_DATA_W-1:0] out_data_out,
  output reg ioc_req_ack_out,
  output reg wdb_wr_out,
  output reg [`CTS_IDX_W-1:0] wdb_idx_out,
  output reg [`CTS_DATA_W-1:0] wdb_data_out,
  output reg mem_cmd_valid_out,
  output reg mem_cmd_write_out,
  output reg mem_cmd_marked_out,
  output reg [`CTS_IDX_W-1:0] mem_cmd_idx_out,
  output reg [`CTS_ADDR_W-1:0] mem_cmd_addr_out,
  output reg ioc_valid_out,
  output reg [`CTS_IOK_W-1:0] ioc_kind_out,
  output reg [`CTS_ADDR_W-1:0] ioc_addr_out,
  output reg [`CTS_DATA_W-1:0] ioc_data_out
);

  reg [`CTS_ENTRIES-1:0] wvalid;
  reg [`CTS_ENTRIES-1:0] wissued;
  reg [`CTS_ADDR_W-1:0] waddr [0:`CTS_ENTRIES-1];
  reg [`CTS_ENTRIES-1:0] rvalid;
  reg [`CTS_ENTRIES-1:0] rcoh;
  reg [`CTS_ENTRIES-1:0] rcdone;
  reg [`CTS_ENTRIES-1:0] rfin;
  reg [`CTS_ENTRIES-1:0] rinrq;
  reg [`CTS_ENTRIES-1:0] rdval;
  reg [`CTS_RESP_W-1:0] rresp [0:`CTS_ENTRIES-1];
  reg [`CTS_IDX_W-1:0] rout [0:`CTS_ENTRIES-1];
  reg [`CTS_ADDR_W-1:0] raddr [0:`CTS_ENTRIES-1];
  reg [`CTS_DATA_W-1:0] rdata [0:`CTS_ENTRIES-1];
  reg [`CTS_IDX_W-1:0] wq [0:`CTS_ENTRIES-1];
  reg [`CTS_IDX_W-1:0] rq [0:`CTS_ENTRIES-1];
  reg [`CTS_IDX_W-1:0] coherency_response_queue [0:`CTS_ENTRIES-1];
  reg [`CTS_IDX_W-1:0] rtq [0:`CTS_ENTRIES-1];
  reg [`CTS_IDX_W-1:0] wq_head, rq_head, crq_head, rtq_head;
  reg [`CTS_CNT_W-1:0] wq_cnt, rq_cnt, crq_cnt, rtq_cnt;
  reg crq_hit;

  function [`CTS_IDX_W-1:0] cts_first_free;
    input [`CTS_ENTRIES-1:0] used;
    integer i;
    begin
      cts_first_free = `CTS_IDX_ZERO;
      for (i = `CTS_ENTRIES - 1; i >= 0; i = i - 1) begin
        if (!used[i]) begin
          cts_first_free = i[`CTS_IDX_W-1:0];
        end
      end
    end
  endfunction

  function [`CTS_CNT_W-1:0] cts_free_cnt;
    input [`CTS_ENTRIES-1:0] used;
    integer i;
    begin
      cts_free_cnt = `CTS_CNT_ZERO;
      for (i = 0; i < `CTS_ENTRIES; i = i + 1) begin
        cts_free_cnt = cts_free_cnt + {2'h0, ~used[i]};
      end
    end
  endfunction

  function [`CTS_IDX_W-1:0] cts_slot;
    input [`CTS_IDX_W-1:0] head;
    input [`CTS_CNT_W-1:0] cnt;
    begin
      cts_slot = head + cnt[`CTS_IDX_W-1:0];
    end
  endfunction

  function [`CTS_CNT_W-1:0] cts_cnt;
    input [`CTS_CNT_W-1:0] cnt;
    input push;
    input pop;
    begin
      cts_cnt = cnt + {2'h0, push} - {2'h0, pop};
    end
  endfunction

  // A read conflicts while a write to the same line is held but not yet issued.
  function cts_conflict;
    input [`CTS_ADDR_W-1:0] addr;
    input [`CTS_ENTRIES-1:0] valid;
    input [`CTS_ENTRIES-1:0] issued;
    input [`CTS_ENTRIES*`CTS_ADDR_W-1:0] addrs;
    integer i;
    begin
      cts_conflict = 1'b0;
      for (i = 0; i < `CTS_ENTRIES; i = i + 1) begin
        if (valid[i] && !issued[i] && addrs[i*`CTS_ADDR_W +: `CTS_ADDR_W] == addr) begin
          cts_conflict = 1'b1;
        end
      end
    end
  endfunction

  reg [`CTS_ENTRIES*`CTS_ADDR_W-1:0] waddr_flat;
  reg [`CTS_IDX_W-1:0] wfree, rfree, wq_idx, rq_idx, crq_idx, rtq_idx;
  reg acc_w, acc_r, acc_coh, rq_conf, crq_conf, drain, slot_free;
  reg sel_wr, sel_reissue, sel_rq, sel_bypass, crq_record, crq_pop, crq_ok;
  reg early_push, send_ret, send_ioc;
  integer k;
  integer m;

  always @* begin
    for (k = 0; k < `CTS_ENTRIES; k = k + 1) begin
      waddr_flat[k*`CTS_ADDR_W +: `CTS_ADDR_W] = waddr[k];
    end
    wfree = cts_first_free(wvalid);
    rfree = cts_first_free(rvalid);
    wq_idx = wq[wq_head];
    rq_idx = rq[rq_head];
    crq_idx = coherency_response_queue[crq_head];
    rtq_idx = rtq[rtq_head];
    acc_w = bus_valid_in && !(&wvalid) &&
      (bus_kind_in == `CTS_KIND_WRITE || bus_kind_in == `CTS_KIND_C2C);
    acc_r = bus_valid_in && !(&rvalid) &&
      (bus_kind_in == `CTS_KIND_NCREAD || bus_kind_in == `CTS_KIND_CREAD);
    acc_coh = acc_r && bus_kind_in == `CTS_KIND_CREAD;
    rq_conf = cts_conflict(raddr[rq_idx], wvalid, wissued, waddr_flat);
    crq_conf = cts_conflict(raddr[crq_idx], wvalid, wissued, waddr_flat);
    slot_free = !mem_cmd_valid_out || mem_cmd_ready_in;
    drain = (wq_cnt != `CTS_CNT_ZERO) && (((rq_cnt != `CTS_CNT_ZERO) && rq_conf) ||
      ((crq_cnt != `CTS_CNT_ZERO) && rcdone[crq_idx] && crq_hit));
    sel_wr = slot_free && drain;
    sel_reissue = slot_free && !sel_wr && (crq_cnt != `CTS_CNT_ZERO) && rcdone[crq_idx] &&
      crq_hit && !crq_conf && !rinrq[crq_idx] && !mem_rd_early_in;
    sel_rq = slot_free && !sel_wr && !sel_reissue && (rq_cnt != `CTS_CNT_ZERO) &&
      !rq_conf;
    sel_bypass = slot_free && !sel_wr && !sel_reissue && acc_r &&
      (rq_cnt == `CTS_CNT_ZERO) && !cts_conflict(bus_addr_in, wvalid, wissued, waddr_flat);
    if (slot_free && !sel_reissue && !sel_rq && !sel_bypass && (wq_cnt != `CTS_CNT_ZERO)) begin
      sel_wr = 1'b1;
    end
    crq_record = coh_resp_valid_in && (crq_cnt != `CTS_CNT_ZERO) && !rcdone[crq_idx];
    // A pop in the same cycle as an early index would need two return pushes.
    crq_pop = sel_reissue || ((crq_cnt != `CTS_CNT_ZERO) && rcdone[crq_idx] && !crq_hit &&
      !mem_rd_early_in);
    crq_ok = rresp[crq_idx] != `CTS_RESP_COPYOUT;
    early_push = mem_rd_early_in && rout[mem_rd_early_idx_in] == `CTS_OUT_ONE &&
      (!rcoh[mem_rd_early_idx_in] ||
      (rfin[mem_rd_early_idx_in] && rresp[mem_rd_early_idx_in] != `CTS_RESP_COPYOUT));
    // A grant counts only once our request has stood on the bus for a cycle.
    send_ret = bus_req_out && bus_grant_in && (rtq_cnt != `CTS_CNT_ZERO) &&
      rdval[rtq_idx];
    send_ioc = bus_req_out && bus_grant_in && !send_ret && ioc_req_valid_in &&
      !ioc_req_ack_out;
  end

  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wvalid <= 4'h0;
      wissued <= 4'h0;
      rvalid <= 4'h0;
      rcoh <= 4'h0;
      rcdone <= 4'h0;
      rfin <= 4'h0;
      rinrq <= 4'h0;
      rdval <= 4'h0;
      for (m = 0; m < `CTS_ENTRIES; m = m + 1) begin
        waddr[m] <= 32'h0;
        raddr[m] <= 32'h0;
        rdata[m] <= 64'h0;
        rresp[m] <= `CTS_RESP_OK;
        rout[m] <= `CTS_OUT_ZERO;
        wq[m] <= `CTS_IDX_ZERO;
        rq[m] <= `CTS_IDX_ZERO;
        coherency_response_queue[m] <= `CTS_IDX_ZERO;
        rtq[m] <= `CTS_IDX_ZERO;
      end
      wq_head <= `CTS_IDX_ZERO;
      rq_head <= `CTS_IDX_ZERO;
      crq_head <= `CTS_IDX_ZERO;
      rtq_head <= `CTS_IDX_ZERO;
      wq_cnt <= `CTS_CNT_ZERO;
      rq_cnt <= `CTS_CNT_ZERO;
      crq_cnt <= `CTS_CNT_ZERO;
      rtq_cnt <= `CTS_CNT_ZERO;
      crq_hit <= 1'b0;
      bus_busy_out <= 1'b0;
      bus_req_out <= 1'b0;
      out_valid_out <= 1'b0;
      out_return_out <= 1'b0;
      out_write_out <= 1'b0;
      out_addr_out <= 32'h0;
      out_data_out <= 64'h0;
      ioc_req_ack_out <= 1'b0;
      wdb_wr_out <= 1'b0;
      wdb_idx_out <= `CTS_IDX_ZERO;
      wdb_data_out <= 64'h0;
      mem_cmd_valid_out <= 1'b0;
      mem_cmd_write_out <= 1'b0;
      mem_cmd_marked_out <= 1'b0;
      mem_cmd_idx_out <= `CTS_IDX_ZERO;
      mem_cmd_addr_out <= 32'h0;
      ioc_valid_out <= 1'b0;
      ioc_kind_out <= `CTS_IOK_C2C;
      ioc_addr_out <= 32'h0;
      ioc_data_out <= 64'h0;
    end else begin
      // Busy warns one entry early because the flag reaches the bus a cycle late.
      bus_busy_out <= cts_free_cnt(wvalid) < `CTS_MAP_LOW || cts_free_cnt(rvalid) < `CTS_MAP_LOW;
      bus_req_out <= (rtq_cnt != `CTS_CNT_ZERO) || ioc_req_valid_in;
      wdb_wr_out <= acc_w;
      wdb_idx_out <= wfree;
      wdb_data_out <= bus_data_in;
      if (acc_w) begin
        wvalid[wfree] <= 1'b1;
        wissued[wfree] <= 1'b0;
        waddr[wfree] <= bus_addr_in;
        wq[cts_slot(wq_head, wq_cnt)] <= wfree;
      end
      if (mem_wr_done_in) begin
        wvalid[mem_wr_done_idx_in] <= 1'b0;
      end
      ioc_valid_out <= 1'b0;
      if (acc_w && bus_kind_in == `CTS_KIND_C2C && bus_master_id_in == `CTS_IOC_ID) begin
        ioc_valid_out <= 1'b1;
        ioc_kind_out <= `CTS_IOK_C2C;
        ioc_addr_out <= bus_addr_in;
        ioc_data_out <= bus_data_in;
      end else if (acc_coh) begin
        ioc_valid_out <= 1'b1;
        ioc_kind_out <= `CTS_IOK_SNOOP;
        ioc_addr_out <= bus_addr_in;
        ioc_data_out <= 64'h0;
      end else if (bus_valid_in && bus_kind_in == `CTS_KIND_RETURN &&
        bus_master_id_in == `CTS_IOC_ID) begin
        ioc_valid_out <= 1'b1;
        ioc_kind_out <= `CTS_IOK_RETURN;
        ioc_addr_out <= bus_addr_in;
        ioc_data_out <= bus_data_in;
      end
      if (acc_r) begin
        rvalid[rfree] <= 1'b1;
        rcoh[rfree] <= acc_coh;
        rcdone[rfree] <= 1'b0;
        rfin[rfree] <= 1'b0;
        rdval[rfree] <= 1'b0;
        raddr[rfree] <= bus_addr_in;
        rinrq[rfree] <= !sel_bypass;
        rout[rfree] <= sel_bypass ? `CTS_OUT_ONE : `CTS_OUT_ZERO;
        if (!sel_bypass) begin
          rq[cts_slot(rq_head, rq_cnt)] <= rfree;
        end
        if (acc_coh) begin
          coherency_response_queue[cts_slot(crq_head, crq_cnt)] <= rfree;
        end
      end
      if (mem_cmd_valid_out && mem_cmd_ready_in) begin
        mem_cmd_valid_out <= 1'b0;
      end
      if (sel_wr) begin
        mem_cmd_valid_out <= 1'b1;
        mem_cmd_write_out <= 1'b1;
        mem_cmd_marked_out <= 1'b0;
        mem_cmd_idx_out <= wq_idx;
        mem_cmd_addr_out <= waddr[wq_idx];
        wissued[wq_idx] <= 1'b1;
      end else if (sel_reissue) begin
        mem_cmd_valid_out <= 1'b1;
        mem_cmd_write_out <= 1'b0;
        mem_cmd_marked_out <= 1'b1;
        mem_cmd_idx_out <= crq_idx;
        mem_cmd_addr_out <= raddr[crq_idx];
        rout[crq_idx] <= rout[crq_idx] + `CTS_OUT_ONE;
        rdval[crq_idx] <= 1'b0;
      end else if (sel_rq) begin
        mem_cmd_valid_out <= 1'b1;
        mem_cmd_write_out <= 1'b0;
        mem_cmd_marked_out <= 1'b0;
        mem_cmd_idx_out <= rq_idx;
        mem_cmd_addr_out <= raddr[rq_idx];
        rinrq[rq_idx] <= 1'b0;
        rout[rq_idx] <= rout[rq_idx] + `CTS_OUT_ONE;
      end else if (sel_bypass) begin
        mem_cmd_valid_out <= 1'b1;
        mem_cmd_write_out <= 1'b0;
        mem_cmd_marked_out <= 1'b0;
        mem_cmd_idx_out <= rfree;
        mem_cmd_addr_out <= bus_addr_in;
      end
      if (crq_record) begin
        rcdone[crq_idx] <= 1'b1;
        rresp[crq_idx] <= coh_resp_in;
        crq_hit <= cts_conflict(raddr[crq_idx], wvalid, wissued, waddr_flat);
      end
      if (crq_pop) begin
        rfin[crq_idx] <= 1'b1;
        crq_hit <= 1'b0;
        if (crq_ok && rout[crq_idx] == `CTS_OUT_ZERO && !sel_reissue) begin
          if (rdval[crq_idx]) begin
            rtq[cts_slot(rtq_head, rtq_cnt)] <= crq_idx;
          end
        end else if (!crq_ok && rout[crq_idx] == `CTS_OUT_ZERO && !sel_reissue) begin
          rvalid[crq_idx] <= 1'b0;
        end
      end
      if (mem_rd_early_in) begin
        rout[mem_rd_early_idx_in] <= rout[mem_rd_early_idx_in] - `CTS_OUT_ONE;
        if (early_push) begin
          rtq[cts_slot(rtq_head, rtq_cnt)] <= mem_rd_early_idx_in;
        end else if (rout[mem_rd_early_idx_in] == `CTS_OUT_ONE && rfin[mem_rd_early_idx_in]) begin
          // Copy-out answers never return memory data, so the late data only frees.
          rvalid[mem_rd_early_idx_in] <= 1'b0;
        end
      end
      if (mem_rd_data_valid_in) begin
        rdata[mem_rd_data_idx_in] <= mem_rd_data_in;
        rdval[mem_rd_data_idx_in] <= 1'b1;
      end
      out_valid_out <= send_ret || send_ioc;
      ioc_req_ack_out <= send_ioc;
      if (send_ret) begin
        out_return_out <= 1'b1;
        out_write_out <= 1'b0;
        out_addr_out <= raddr[rtq_idx];
        out_data_out <= rdata[rtq_idx];
        rvalid[rtq_idx] <= 1'b0;
      end else if (send_ioc) begin
        out_return_out <= 1'b0;
        out_write_out <= ioc_req_write_in;
        out_addr_out <= ioc_req_addr_in;
        out_data_out <= ioc_req_data_in;
      end
      if (sel_wr) begin
        wq_head <= wq_head + 2'h1;
      end
      if (sel_rq) begin
        rq_head <= rq_head + 2'h1;
      end
      if (crq_pop) begin
        crq_head <= crq_head + 2'h1;
      end
      if (send_ret) begin
        rtq_head <= rtq_head + 2'h1;
      end
      wq_cnt <= cts_cnt(wq_cnt, acc_w, sel_wr);
      rq_cnt <= cts_cnt(rq_cnt, acc_r && !sel_bypass, sel_rq);
      crq_cnt <= cts_cnt(crq_cnt, acc_coh, crq_pop);
      rtq_cnt <= cts_cnt(rtq_cnt, early_push || (crq_pop && crq_ok && !sel_reissue &&
        rout[crq_idx] == `CTS_OUT_ZERO && rdval[crq_idx]), send_ret);
    end
  end

endmodule

// File: include/cts_map.vh
/*
  Constants for the coherent transaction scheduler: widths, map depth,
  transaction kinds, coherency response codes and the I/O controller's
  master identifier. Included by the scheduler, its properties, the dram model and the bench.
*/
`ifndef CTS_MAP_VH
`define CTS_MAP_VH

`define CTS_ADDR_W 32
`define CTS_DATA_W 64
`define CTS_IDX_W 2
`define CTS_ENTRIES 4
`define CTS_CNT_W 3
`define CTS_CNT_FULL 3'h4
`define CTS_CNT_ZERO 3'h0
`define CTS_IDX_ZERO 2'h0
`define CTS_OUT_ZERO 2'h0
`define CTS_OUT_ONE 2'h1
`define CTS_MAP_LOW 3'h2

`define CTS_KIND_W 3
`define CTS_KIND_WRITE 3'h0
`define CTS_KIND_C2C 3'h1
`define CTS_KIND_NCREAD 3'h2
`define CTS_KIND_CREAD 3'h3
`define CTS_KIND_RETURN 3'h4

`define CTS_RESP_W 2
`define CTS_RESP_OK 2'h0
`define CTS_RESP_SHARED 2'h1
`define CTS_RESP_COPYOUT 2'h2

`define CTS_IOK_W 2
`define CTS_IOK_C2C 2'h0
`define CTS_IOK_SNOOP 2'h1
`define CTS_IOK_RETURN 2'h2

`define CTS_ID_W 3
// Arbitrary value for the I/O controller's bus master identifier.
`define CTS_IOC_ID 3'h5

`endif

// File: verification/cts_scheduler_properties.sv
/* Port assertions and covers for the scheduler, bound to its top module.
   Assumes one clock domain and the active-high asynchronous reset. */
`timescale 1ns/10ps
`include "cts_map.vh"
module cts_scheduler_properties (
  input wire mclk_in, sys_rst_in, bus_valid_in, bus_grant_in, mem_cmd_ready_in,
  input wire [`CTS_KIND_W-1:0] bus_kind_in,
  input wire [`CTS_ID_W-1:0] bus_master_id_in,
  input wire [`CTS_ADDR_W-1:0] bus_addr_in, mem_cmd_addr_out, ioc_addr_out,
  input wire [`CTS_DATA_W-1:0] bus_data_in, wdb_data_out, ioc_data_out,
  input wire bus_busy_out, bus_req_out, out_valid_out, out_return_out, ioc_req_ack_out,
  input wire wdb_wr_out, mem_cmd_valid_out, mem_cmd_write_out, mem_cmd_marked_out,
  input wire ioc_valid_out,
  input wire [`CTS_IDX_W-1:0] mem_cmd_idx_out,
  input wire [`CTS_IOK_W-1:0] ioc_kind_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // Busy warns below two free entries, so a transaction seen while it is low always fits.
  wire take = bus_valid_in && !bus_busy_out;
  wire is_wr = bus_kind_in == `CTS_KIND_WRITE || bus_kind_in == `CTS_KIND_C2C;
  wdb_take_a:
    assert property (take && is_wr |=> wdb_wr_out && wdb_data_out == $past(bus_data_in))
    else $error("write data not passed to the buffer");
  wdb_cause_a:
    assert property (wdb_wr_out |-> $past(bus_valid_in) && $past(is_wr))
    else $error("buffer write without a bus write");
  c2c_copy_a:
    assert property (take && bus_kind_in == `CTS_KIND_C2C && bus_master_id_in == `CTS_IOC_ID
      |=> ioc_valid_out && ioc_kind_out == `CTS_IOK_C2C && ioc_addr_out == $past(bus_addr_in))
    else $error("copy write not sent to io controller");
  snoop_fwd_a:
    assert property (take && bus_kind_in == `CTS_KIND_CREAD
      |=> ioc_valid_out && ioc_kind_out == `CTS_IOK_SNOOP && ioc_addr_out == $past(bus_addr_in))
    else $error("coherent read not sent for snoop");
  ret_to_ioc_a:
    assert property (bus_valid_in && bus_kind_in == `CTS_KIND_RETURN
      && bus_master_id_in == `CTS_IOC_ID
      |=> ioc_valid_out && ioc_kind_out == `CTS_IOK_RETURN && ioc_data_out == $past(bus_data_in))
    else $error("return data not delivered to io controller");
  cmd_hold_a:
    assert property (mem_cmd_valid_out && !mem_cmd_ready_in |=> mem_cmd_valid_out
      && $stable(mem_cmd_addr_out) && $stable(mem_cmd_idx_out) && $stable(mem_cmd_write_out))
    else $error("memory command changed before taken");
  marked_read_a:
    assert property (mem_cmd_valid_out && mem_cmd_marked_out |-> !mem_cmd_write_out)
    else $error("marked flag on a write");
  read_bypass_a:
    assert property (take && bus_kind_in == `CTS_KIND_NCREAD && !mem_cmd_valid_out
      |-> ##[1:6] mem_cmd_valid_out && !mem_cmd_write_out)
    else $error("read not issued to memory in time");
  out_grant_a:
    assert property (out_valid_out |-> $past(bus_grant_in) && $past(bus_req_out))
    else $error("bus driven without request and grant");
  ack_out_a:
    assert property (ioc_req_ack_out |-> out_valid_out && !out_return_out)
    else $error("io request taken without driving it");
  cover property (take && is_wr ##1 wdb_wr_out);
  cover property (out_valid_out && out_return_out);
  cover property (ioc_req_ack_out);
endmodule

bind cts_scheduler cts_scheduler_properties cts_scheduler_properties_inst (.*);

// File: verification/cts_dram_model.sv
/* Behavioural dram sequencer facing the scheduler's memory port.
   Assumes the scheduler's clock and reset; one command in flight at a time. */
`timescale 1ns/10ps
`include "cts_map.vh"
module cts_dram_model (
  input wire mclk_in,
  input wire sys_rst_in,
  input wire hold_in,
  input wire cmd_valid_in,
  input wire cmd_write_in,
  input wire [`CTS_IDX_W-1:0] cmd_idx_in,
  input wire [`CTS_ADDR_W-1:0] cmd_addr_in,
  output wire ready_out,
  output logic wr_done_out,
  output logic rd_early_out,
  output logic rd_data_valid_out,
  output logic [`CTS_IDX_W-1:0] idx_out,
  output logic [`CTS_DATA_W-1:0] rd_data_out
);
  logic busy, wr;
  logic [2:0] cnt;
  logic [`CTS_IDX_W-1:0] idx;
  logic [`CTS_ADDR_W-1:0] addr;
  // Strictly one command at a time, so no read ever passes another.
  assign ready_out = !busy && !hold_in;
  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy <= 1'b0;
      wr <= 1'b0;
      cnt <= 3'h0;
      idx <= '0;
      addr <= '0;
      wr_done_out <= 1'b0;
      rd_early_out <= 1'b0;
      rd_data_valid_out <= 1'b0;
      idx_out <= '0;
      rd_data_out <= '0;
    end else begin
      wr_done_out <= busy && wr && cnt == 3'h1;
      rd_data_valid_out <= busy && !wr && cnt == 3'h2;
      rd_early_out <= busy && !wr && cnt == 3'h1;
      // Idle lines toggle so a stale value can never look valid.
      idx_out <= busy ? idx : ~idx_out;
      rd_data_out <= (busy && !wr && cnt == 3'h2) ? {addr, ~addr} : ~rd_data_out;
      if (busy) begin
        cnt <= cnt - 3'h1;
        busy <= cnt != 3'h0;
      end
      if (cmd_valid_in && ready_out) begin
        busy <= 1'b1;
        cnt <= 3'h3;
        wr <= cmd_write_in;
        idx <= cmd_idx_in;
        addr <= cmd_addr_in;
      end
    end
  end
endmodule

// File: verification/tb.sv
/* Self-checking bench for the scheduler with a dram sequencer model.
   Assumes the shared header constants and a 10 MHz clock. */
`timescale 1ns/10ps
`include "cts_map.vh"
module tb;
  logic mclk_in, sys_rst_in, bus_valid_in, bus_grant_in, coh_resp_valid_in, mem_cmd_ready_in;
  logic mem_wr_done_in, mem_rd_early_in, mem_rd_data_valid_in, ioc_req_valid_in, hold;
  logic ioc_req_write_in, bus_busy_out, bus_req_out, out_valid_out, out_return_out, fnd;
  logic out_write_out, ioc_req_ack_out, wdb_wr_out, mem_cmd_valid_out, mem_cmd_write_out;
  logic mem_cmd_marked_out, ioc_valid_out;
  logic [`CTS_KIND_W-1:0] bus_kind_in;
  logic [`CTS_ID_W-1:0] bus_master_id_in;
  logic [`CTS_ADDR_W-1:0] bus_addr_in, ioc_req_addr_in, out_addr_out, mem_cmd_addr_out;
  logic [`CTS_ADDR_W-1:0] ioc_addr_out, a;
  logic [`CTS_DATA_W-1:0] bus_data_in, mem_rd_data_in, ioc_req_data_in, out_data_out;
  logic [`CTS_DATA_W-1:0] wdb_data_out, ioc_data_out;
  logic [`CTS_RESP_W-1:0] coh_resp_in;
  logic [`CTS_IDX_W-1:0] mem_wr_done_idx_in, mem_rd_early_idx_in, mem_rd_data_idx_in;
  logic [`CTS_IDX_W-1:0] wdb_idx_out, mem_cmd_idx_out;
  logic [`CTS_IOK_W-1:0] ioc_kind_out;
  int n_fail, cmp_count, i, k;
  time wr_t, rd_t;
  typedef struct {logic [2:0] kind; logic [2:0] id; logic wdb; logic io_controller; logic [1:0] iok;
    int dly; logic [1:0] resp; logic ret;} cts_row_t;
  cts_row_t rows [9] = '{
    '{`CTS_KIND_WRITE, 3'h1, 1, 0, 2'h0, 0, 2'h0, 0},
    '{`CTS_KIND_C2C, `CTS_IOC_ID, 1, 1, `CTS_IOK_C2C, 0, 2'h0, 0},
    '{`CTS_KIND_C2C, 3'h2, 1, 0, 2'h0, 0, 2'h0, 0},
    '{`CTS_KIND_NCREAD, 3'h1, 0, 0, 2'h0, 0, 2'h0, 1},
    '{`CTS_KIND_CREAD, 3'h1, 0, 1, `CTS_IOK_SNOOP, 1, `CTS_RESP_OK, 1},
    '{`CTS_KIND_CREAD, 3'h2, 0, 1, `CTS_IOK_SNOOP, 12, `CTS_RESP_SHARED, 1},
    '{`CTS_KIND_CREAD, 3'h2, 0, 1, `CTS_IOK_SNOOP, 2, `CTS_RESP_COPYOUT, 0},
    '{`CTS_KIND_RETURN, `CTS_IOC_ID, 0, 1, `CTS_IOK_RETURN, 0, 2'h0, 0},
    '{`CTS_KIND_RETURN, 3'h1, 0, 0, 2'h0, 0, 2'h0, 0}};
  assign mem_rd_early_idx_in = mem_wr_done_idx_in;
  assign mem_rd_data_idx_in = mem_wr_done_idx_in;
  cts_scheduler cts_scheduler_inst (.*);
  cts_dram_model cts_dram_model_inst (.mclk_in, .sys_rst_in, .hold_in(hold),
    .cmd_valid_in(mem_cmd_valid_out), .cmd_write_in(mem_cmd_write_out),
    .cmd_idx_in(mem_cmd_idx_out), .cmd_addr_in(mem_cmd_addr_out), .ready_out(mem_cmd_ready_in),
    .wr_done_out(mem_wr_done_in), .rd_early_out(mem_rd_early_in),
    .rd_data_valid_out(mem_rd_data_valid_in), .idx_out(mem_wr_done_idx_in),
    .rd_data_out(mem_rd_data_in));
  task give_verdict;
    $display("Counts: %0d compared, %0d mismatched", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [2:0] kind, input logic [2:0] id, input logic [31:0] ad);
    @(posedge mclk_in);
    bus_valid_in <= 1'b1;
    bus_kind_in <= kind;
    bus_master_id_in <= id;
    bus_addr_in <= ad;
    bus_data_in <= {~ad, ad};
    @(posedge mclk_in);
    bus_valid_in <= 1'b0;
    bus_addr_in <= ~ad;
    bus_data_in <= {ad, ~ad};
  endtask
  task automatic wait_ret(input logic [31:0] ad, input logic exp, input logic coh, input int dly,
      input logic [1:0] resp);
    logic seen;
    seen = 1'b0;
    for (int j = 0; j < 60; j++) begin
      coh_resp_valid_in <= coh && j == dly;
      coh_resp_in <= resp;
      @(posedge mclk_in);
      if (out_valid_out && out_return_out && !seen) begin
        seen = 1'b1;
        chk("ret_data", {ad, ~ad}, out_data_out);
      end
    end
    chk("ret_seen", exp, seen);
    if (exp && !seen) give_verdict();
  endtask
  // Order of memory commands for the conflict address, read at the edge.
  always @(posedge mclk_in) begin
    if (mem_cmd_valid_out && mem_cmd_ready_in && mem_cmd_addr_out == 32'h2003) begin
      if (mem_cmd_write_out) wr_t = $time;
      else rd_t = $time;
    end
  end
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  initial begin
    {sys_rst_in, hold, wr_t, rd_t, n_fail, cmp_count} = '0;
    sys_rst_in = 1'b1;
    {bus_valid_in, bus_kind_in, bus_master_id_in, bus_addr_in, bus_data_in, bus_grant_in} = '0;
    {coh_resp_valid_in, coh_resp_in, ioc_req_valid_in, ioc_req_write_in} = '0;
    {ioc_req_addr_in, ioc_req_data_in} = '0;
    repeat (4) @(posedge mclk_in);
    chk("rst_busy", 1'b0, bus_busy_out);
    chk("rst_cmd", 1'b0, mem_cmd_valid_out);
    chk("rst_out", 1'b0, out_valid_out);
    sys_rst_in <= 1'b0;
    bus_grant_in <= 1'b1;
    $display("Reset test done");
    for (k = 0; k < 9; k++) begin
      a = 32'h1000 + 32'(k) * 32'h10;
      send(rows[k].kind, rows[k].id, a);
      @(posedge mclk_in);
      chk("wdb_wr", rows[k].wdb, wdb_wr_out);
      if (rows[k].wdb) chk("wdb_data", {~a, a}, wdb_data_out);
      if (rows[k].wdb) chk("wdb_idx", 2'h0, wdb_idx_out);
      chk("ioc_valid", rows[k].io_controller, ioc_valid_out);
      if (rows[k].io_controller) chk("ioc_kind", rows[k].iok, ioc_kind_out);
      wait_ret(a, rows[k].ret, rows[k].kind == `CTS_KIND_CREAD, rows[k].dly, rows[k].resp);
      $display("Row %0d done", k);
    end
    hold <= 1'b1;
    for (k = 0; k < 4; k++) send(`CTS_KIND_WRITE, 3'h1, 32'h2000 + 32'(k));
    @(posedge mclk_in);
    chk("busy_full", 1'b1, bus_busy_out);
    send(`CTS_KIND_WRITE, 3'h1, 32'h2100);
    @(posedge mclk_in);
    chk("refused", 1'b0, wdb_wr_out);
    send(`CTS_KIND_NCREAD, 3'h1, 32'h2003);
    hold <= 1'b0;
    wait_ret(32'h2003, 1'b1, 1'b0, 0, 2'h0);
    chk("rd_after_wr", 1'b1, rd_t > wr_t);
    $display("Conflict test done");
    for (k = 0; k < 2; k++) begin
      @(posedge mclk_in);
      ioc_req_valid_in <= 1'b1;
      ioc_req_write_in <= k == 0;
      ioc_req_addr_in <= 32'h3000 + 32'(k);
      ioc_req_data_in <= 64'h77;
      fnd = 1'b0;
      for (i = 0; i < 20 && !fnd; i++) begin
        @(posedge mclk_in);
        fnd = ioc_req_ack_out;
      end
      ioc_req_valid_in <= 1'b0;
      chk("ioc_ack", 1'b1, fnd);
      if (!fnd) give_verdict();
      chk("out_write", k == 0, out_write_out);
      chk("out_addr", 32'h3000 + 32'(k), out_addr_out);
      if (k == 0) chk("out_data", 64'h77, out_data_out);
    end
    $display("Io request test done");
    give_verdict();
  end
endmodule
